// ==== hdl/serdes_rx_regs.vh ====
// register map, field positions, reset values and timing figures of the receive block
// assumes a 40 MHz system clock and a word-aligned AHB-Lite register port
// Contract
// - lock only within 200 PPM, retime input
// - split 20-bit word into two decoders
// - search stream for comma, either polarity
// - only positive comma moves word boundary
// - both decoders captured in 16-bit register
// - low flag marks control byte on 0-7
// - high flag marks control byte on 8-15
// - accept only the twelve listed control characters
// - decode error lane shows K0.0
// - signal loss shows K31.7 both lanes
// - signal loss drives flags and bus high
// - disabled: serial out, bus, low flag float
// - pattern errors drive low flag low
// - serial rate is twenty bits per word
// - loopback routes serial internally, output floats
// - pattern plus loopback reports self-test on low flag
// - power-on reset floats outputs, word clock low; serial out is still driven whenever enabled outside loopback
// - first serial bit is bus bit 0
// - pattern test uses 2^7-1 sequence
`ifndef SERDES_RX_REGS_VH
`define SERDES_RX_REGS_VH

`define REG_CONTROL 8'h00
`define REG_STATUS 8'h04
`define REG_LAST_WORD 8'h08
`define REG_PATTERN_ERRORS 8'h0C
`define REG_DECODE_ERRORS 8'h10

`define CTRL_ENABLE_BIT 0
`define CTRL_PATTERN_BIT 1
`define CTRL_LOOPBACK_BIT 2
`define CTRL_RESET 3'h1

`define STAT_LOCK_BIT 0
`define STAT_LOSS_BIT 1
`define STAT_ALIGNED_BIT 2
`define STAT_INV_COMMA_BIT 3
`define STAT_POR_BIT 4

`define WORD_BITS 5'h14
`define HALF_BITS 5'h0A
`define COMMA_POSITIVE 7'h7C
`define COMMA_NEGATIVE 7'h03
`define COMMA_LEN 5'h07

`define CODE_ERROR 8'h00
`define CODE_LOSS 8'hFF

`define CLK_PERIOD_NS 25
`define LINK_BIT_PERIOD_NS 100
`define LOCK_PPM 200
`define POR_TIME_US 1000

`endif

// ==== hdl/symbol_decoder_8b10b.v ====
// combinational 8b/10b decoder for one 10-bit symbol, bit 0 is the first bit on the line
// assumes the caller registers the result
`timescale 1ns/1ps
module symbol_decoder_8b10b (
  input wire [9:0] symbol_i,
  output reg [7:0] byte_o,
  output reg control_o,
  output reg error_o
);
  reg [5:0] s6;
  reg [3:0] f4;
  reg [4:0] x5;
  reg [2:0] y3;
  reg ok6;
  reg ok4;
  reg k28;
  reg alt7;

  always @*
  begin
    s6 = {symbol_i[0], symbol_i[1], symbol_i[2], symbol_i[3], symbol_i[4], symbol_i[5]};
    f4 = {symbol_i[6], symbol_i[7], symbol_i[8], symbol_i[9]};
    ok6 = 1'b1;
    ok4 = 1'b1;
    k28 = (s6 == 6'h0F) || (s6 == 6'h30);
    alt7 = (f4 == 4'h7) || (f4 == 4'h8);
    case (s6)
      6'h27, 6'h18: x5 = 5'h00;
      6'h1D, 6'h22: x5 = 5'h01;
      6'h2D, 6'h12: x5 = 5'h02;
      6'h31: x5 = 5'h03;
      6'h35, 6'h0A: x5 = 5'h04;
      6'h29: x5 = 5'h05;
      6'h19: x5 = 5'h06;
      6'h38, 6'h07: x5 = 5'h07;
      6'h39, 6'h06: x5 = 5'h08;
      6'h25: x5 = 5'h09;
      6'h15: x5 = 5'h0A;
      6'h34: x5 = 5'h0B;
      6'h0D: x5 = 5'h0C;
      6'h2C: x5 = 5'h0D;
      6'h1C: x5 = 5'h0E;
      6'h17, 6'h28: x5 = 5'h0F;
      6'h1B, 6'h24: x5 = 5'h10;
      6'h23: x5 = 5'h11;
      6'h13: x5 = 5'h12;
      6'h32: x5 = 5'h13;
      6'h0B: x5 = 5'h14;
      6'h2A: x5 = 5'h15;
      6'h1A: x5 = 5'h16;
      6'h3A, 6'h05: x5 = 5'h17;
      6'h33, 6'h0C: x5 = 5'h18;
      6'h26: x5 = 5'h19;
      6'h16: x5 = 5'h1A;
      6'h36, 6'h09: x5 = 5'h1B;
      6'h0E: x5 = 5'h1C;
      6'h2E, 6'h11: x5 = 5'h1D;
      6'h1E, 6'h21: x5 = 5'h1E;
      6'h2B, 6'h14: x5 = 5'h1F;
      6'h0F, 6'h30: x5 = 5'h1C;
      default:
      begin
        x5 = 5'h00;
        ok6 = 1'b0;
      end
    endcase
    case (f4)
      4'hB, 4'h4: y3 = 3'h0;
      4'h9: y3 = 3'h1;
      4'h5: y3 = 3'h2;
      4'hC, 4'h3: y3 = 3'h3;
      4'hD, 4'h2: y3 = 3'h4;
      4'hA: y3 = 3'h5;
      4'h6: y3 = 3'h6;
      4'hE, 4'h1, 4'h7, 4'h8: y3 = 3'h7;
      default:
      begin
        y3 = 3'h0;
        ok4 = 1'b0;
      end
    endcase
    // positive-disparity K28 swaps the ambiguous suffixes
    if (s6 == 6'h30 && (y3 == 3'h1 || y3 == 3'h2 || y3 == 3'h5 || y3 == 3'h6))
      y3 = 3'h7 - y3;
    control_o = k28 || (alt7 && (x5 == 5'h17 || x5 == 5'h1B || x5 == 5'h1D || x5 == 5'h1E));
    // alternate suffix is only legal for a few data codes
    if (alt7 && !control_o && !(x5 == 5'h11 || x5 == 5'h12 || x5 == 5'h14 ||
        x5 == 5'h0B || x5 == 5'h0D || x5 == 5'h0E))
      ok4 = 1'b0;
    error_o = !(ok6 && ok4);
    byte_o = {y3, x5};
  end
endmodule

// ==== hdl/serdes_receive_align_decode.v ====
// receive half of the link: bit sampling, comma alignment, two lane decoders,
// signal-loss and error substitution, pattern checker, loopback and power control
// assumes the link clock and serial pins are asynchronous pins, AHB-Lite master on clk_i
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "serdes_rx_regs.vh"
module serdes_receive_align_decode #(
  parameter LOCK_WINDOW_CYCLES = 40000,
  parameter POR_CYCLES = `POR_TIME_US * 1000 / `CLK_PERIOD_NS - 1
) (
  input wire clk_i,
  input wire reset_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output wire [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  input wire serial_in_positive_i,
  input wire serial_in_negative_i,
  input wire serial_bit_clock_i,
  input wire signal_loss_detect_i,
  input wire loopback_serial_i,
  output wire [15:0] receive_data_o,
  output wire receive_data_oe_o,
  output wire low_byte_control_flag_o,
  output wire low_byte_control_flag_oe_o,
  output wire high_byte_control_flag_o,
  output wire high_byte_control_flag_oe_o,
  output wire recovered_word_clock_o,
  output wire serial_out_negative_o,
  output wire serial_out_negative_oe_o
);
  localparam integer EXPECTED_BITS = LOCK_WINDOW_CYCLES * `CLK_PERIOD_NS / `LINK_BIT_PERIOD_NS;
  localparam integer TOL_RAW = EXPECTED_BITS * `LOCK_PPM / 1000000;
  localparam integer TOL_BITS = (TOL_RAW < 1) ? 1 : TOL_RAW;
  localparam [31:0] LOCK_LOW = EXPECTED_BITS - TOL_BITS;
  localparam [31:0] LOCK_HIGH = EXPECTED_BITS + TOL_BITS;
  localparam [31:0] WINDOW_LAST = LOCK_WINDOW_CYCLES - 1;
  localparam [4:0] WORD_LAST = `WORD_BITS - 5'h01;
  localparam [4:0] HALF_POINT = `HALF_BITS;
  localparam [4:0] COMMA_COUNT = `COMMA_LEN;

  // pin synchronisers
  reg p_meta_q, p_sync_q, n_meta_q, n_sync_q;
  reg lclk_meta_q, lclk_sync_q, lclk_prev_q;
  reg los_meta_q, los_sync_q;
  // bus slave
  reg [31:0] hrdata_q, rd_mux;
  reg hreadyout_q, hresp_q, wr_pend_q;
  reg [7:0] wr_addr_q;
  // control and status
  reg [2:0] ctrl_q;
  reg inv_comma_q, aligned_q, locked_q;
  reg [31:0] por_cnt_q, win_cnt_q, edge_cnt_q;
  reg [15:0] pattern_err_cnt_q, decode_err_cnt_q;
  // word assembly
  reg [19:0] shreg_q;
  reg [4:0] bit_cnt_q;
  reg [6:0] prbs_q;
  reg [2:0] prbs_fill_q;
  reg word_ready_q, prbs_acc_q, prbs_word_err_q;
  // outputs
  reg [15:0] rx_data_q;
  reg low_flag_q, high_flag_q, rx_oe_q, low_oe_q, high_oe_q, wclk_q, tx_neg_q, tx_oe_q;

  wire bit_event = lclk_sync_q ^ lclk_prev_q;
  wire por_busy = (por_cnt_q != POR_CYCLES);
  wire dev_en = ctrl_q[`CTRL_ENABLE_BIT];
  wire pattern_en = ctrl_q[`CTRL_PATTERN_BIT];
  wire loop_en = ctrl_q[`CTRL_LOOPBACK_BIT];
  wire line_bit = p_sync_q & ~n_sync_q;
  wire rx_bit = loop_en ? loopback_serial_i : line_bit;
  wire [19:0] shreg_d = {rx_bit, shreg_q[19:1]};
  wire comma_pos = (shreg_d[19:13] == `COMMA_POSITIVE);
  wire comma_neg = (shreg_d[19:13] == `COMMA_NEGATIVE);
  wire prbs_expect = prbs_q[6] ^ prbs_q[5];
  wire prbs_miss = bit_event && pattern_en && (prbs_fill_q == 3'h7) && (rx_bit != prbs_expect);
  wire word_end = bit_event && !comma_pos && (bit_cnt_q == WORD_LAST);
  wire ahb_take = hsel_i & htrans_i[1] & hready_i;
  wire [7:0] lo_byte, hi_byte;
  wire lo_k, hi_k, lo_err, hi_err;
  wire [31:0] edge_cnt_d = edge_cnt_q + {31'h0, bit_event};

  symbol_decoder_8b10b lo_decoder (
    .symbol_i(shreg_q[9:0]),
    .byte_o(lo_byte),
    .control_o(lo_k),
    .error_o(lo_err)
  );

  symbol_decoder_8b10b hi_decoder (
    .symbol_i(shreg_q[19:10]),
    .byte_o(hi_byte),
    .control_o(hi_k),
    .error_o(hi_err)
  );

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      p_meta_q <= 1'b0;
      p_sync_q <= 1'b0;
      n_meta_q <= 1'b0;
      n_sync_q <= 1'b0;
      lclk_meta_q <= 1'b0;
      lclk_sync_q <= 1'b0;
      lclk_prev_q <= 1'b0;
      los_meta_q <= 1'b0;
      los_sync_q <= 1'b0;
    end
    else
    begin
      p_meta_q <= serial_in_positive_i;
      p_sync_q <= p_meta_q;
      n_meta_q <= serial_in_negative_i;
      n_sync_q <= n_meta_q;
      lclk_meta_q <= serial_bit_clock_i;
      lclk_sync_q <= lclk_meta_q;
      lclk_prev_q <= lclk_sync_q;
      los_meta_q <= signal_loss_detect_i;
      los_sync_q <= los_meta_q;
    end
  end

  always @*
  begin
    case (haddr_i[7:0])
      `REG_CONTROL: rd_mux = {29'h0, ctrl_q};
      `REG_STATUS: rd_mux = {27'h0, por_busy, inv_comma_q, aligned_q, los_sync_q, locked_q};
      `REG_LAST_WORD: rd_mux = {14'h0, high_flag_q, low_flag_q, rx_data_q};
      `REG_PATTERN_ERRORS: rd_mux = {16'h0, pattern_err_cnt_q};
      `REG_DECODE_ERRORS: rd_mux = {16'h0, decode_err_cnt_q};
      default: rd_mux = 32'h0;
    endcase
  end

  // zero-wait slave: read data registered from the address phase
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      hrdata_q <= 32'h0;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      wr_pend_q <= ahb_take & hwrite_i;
      if (ahb_take)
        wr_addr_q <= haddr_i[7:0];
      if (ahb_take && !hwrite_i)
        hrdata_q <= rd_mux;
    end
  end

  // control register and counters; hardware set wins over software clear
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctrl_q <= `CTRL_RESET;
      inv_comma_q <= 1'b0;
      pattern_err_cnt_q <= 16'h0;
      decode_err_cnt_q <= 16'h0;
    end
    else
    begin
      if (wr_pend_q && wr_addr_q == `REG_CONTROL)
        ctrl_q <= hwdata_i[2:0];
      if (bit_event && comma_neg)
        inv_comma_q <= 1'b1;
      else if (wr_pend_q && wr_addr_q == `REG_STATUS)
        inv_comma_q <= 1'b0;
      if (prbs_miss)
        pattern_err_cnt_q <= (pattern_err_cnt_q == 16'hFFFF) ? pattern_err_cnt_q :
          pattern_err_cnt_q + 16'h1;
      else if (wr_pend_q && wr_addr_q == `REG_PATTERN_ERRORS)
        pattern_err_cnt_q <= 16'h0;
      if (word_ready_q && locked_q && (lo_err || hi_err))
        decode_err_cnt_q <= (decode_err_cnt_q == 16'hFFFF) ? decode_err_cnt_q :
          decode_err_cnt_q + 16'h1;
      else if (wr_pend_q && wr_addr_q == `REG_DECODE_ERRORS)
        decode_err_cnt_q <= 16'h0;
    end
  end

  // power-on reset timer
  always @(posedge clk_i)
  begin
    if (reset_i)
      por_cnt_q <= 32'h0;
    else if (por_busy)
      por_cnt_q <= por_cnt_q + 32'h1;
  end

  // bit-rate check over a fixed window against the local rate
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      win_cnt_q <= 32'h0;
      edge_cnt_q <= 32'h0;
      locked_q <= 1'b0;
    end
    else if (win_cnt_q == WINDOW_LAST)
    begin
      win_cnt_q <= 32'h0;
      edge_cnt_q <= 32'h0;
      locked_q <= (edge_cnt_d >= LOCK_LOW) && (edge_cnt_d <= LOCK_HIGH);
    end
    else
    begin
      win_cnt_q <= win_cnt_q + 32'h1;
      edge_cnt_q <= edge_cnt_d;
    end
  end

  // shift in one bit per link clock edge, realign on the positive comma only
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      shreg_q <= 20'h0;
      bit_cnt_q <= 5'h0;
      aligned_q <= 1'b0;
      word_ready_q <= 1'b0;
    end
    else
    begin
      word_ready_q <= word_end;
      if (bit_event)
      begin
        shreg_q <= shreg_d;
        if (comma_pos)
        begin
          bit_cnt_q <= COMMA_COUNT;
          aligned_q <= 1'b1;
        end
        else if (bit_cnt_q == WORD_LAST)
          bit_cnt_q <= 5'h0;
        else
          bit_cnt_q <= bit_cnt_q + 5'h1;
      end
      if (!locked_q)
        aligned_q <= 1'b0;
    end
  end

  // self-synchronising checker for the x^7 + x^6 + 1 sequence
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      prbs_q <= 7'h0;
      prbs_fill_q <= 3'h0;
      prbs_acc_q <= 1'b0;
      prbs_word_err_q <= 1'b0;
    end
    else if (!pattern_en)
    begin
      prbs_fill_q <= 3'h0;
      prbs_acc_q <= 1'b0;
      prbs_word_err_q <= 1'b0;
    end
    else if (bit_event)
    begin
      prbs_q <= {prbs_q[5:0], rx_bit};
      if (prbs_fill_q != 3'h7)
        prbs_fill_q <= prbs_fill_q + 3'h1;
      if (word_end)
      begin
        prbs_word_err_q <= prbs_acc_q | prbs_miss;
        prbs_acc_q <= 1'b0;
      end
      else if (prbs_miss)
        prbs_acc_q <= 1'b1;
    end
  end

  // output word register, valid at the rising word clock
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rx_data_q <= 16'h0;
      low_flag_q <= 1'b0;
      high_flag_q <= 1'b0;
    end
    else if (los_sync_q)
    begin
      rx_data_q <= {`CODE_LOSS, `CODE_LOSS};
      low_flag_q <= 1'b1;
      high_flag_q <= 1'b1;
    end
    else if (word_ready_q && locked_q)
    begin
      if (lo_err)
      begin
        rx_data_q[7:0] <= `CODE_ERROR;
        low_flag_q <= 1'b1;
      end
      else
      begin
        rx_data_q[7:0] <= lo_byte;
        low_flag_q <= lo_k;
      end
      if (hi_err)
      begin
        rx_data_q[15:8] <= `CODE_ERROR;
        high_flag_q <= 1'b1;
      end
      else
      begin
        rx_data_q[15:8] <= hi_byte;
        high_flag_q <= hi_k;
      end
      if (pattern_en)
        low_flag_q <= ~prbs_word_err_q;
    end
  end

  // pin enables, word clock and transmit leg
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rx_oe_q <= 1'b0;
      low_oe_q <= 1'b0;
      high_oe_q <= 1'b0;
      wclk_q <= 1'b0;
      tx_neg_q <= 1'b0;
      tx_oe_q <= 1'b0;
    end
    else
    begin
      rx_oe_q <= !por_busy && dev_en;
      low_oe_q <= !por_busy && dev_en;
      high_oe_q <= !por_busy;
      wclk_q <= !por_busy && (bit_cnt_q >= HALF_POINT);
      tx_neg_q <= ~loopback_serial_i;
      tx_oe_q <= dev_en && !loop_en;
    end
  end

  assign hrdata_o = hrdata_q;
  assign hreadyout_o = hreadyout_q;
  assign hresp_o = hresp_q;
  assign receive_data_o = rx_data_q;
  assign receive_data_oe_o = rx_oe_q;
  assign low_byte_control_flag_o = low_flag_q;
  assign low_byte_control_flag_oe_o = low_oe_q;
  assign high_byte_control_flag_o = high_flag_q;
  assign high_byte_control_flag_oe_o = high_oe_q;
  assign recovered_word_clock_o = wclk_q;
  assign serial_out_negative_o = tx_neg_q;
  assign serial_out_negative_oe_o = tx_oe_q;
endmodule

// ==== tb/serdes_rx_sva.sv ====
// port checker for the receive block
// assumes clk_i with synchronous active-high reset_i; bound below
`timescale 1ns/1ps
module serdes_rx_sva #(
  parameter LOCK_WINDOW_CYCLES = 400,
  parameter POR_CYCLES = 20
) (
  input wire clk_i,
  input wire reset_i,
  input wire hsel_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire hready_i,
  input wire [31:0] hrdata_o,
  input wire signal_loss_detect_i,
  input wire loopback_serial_i,
  input wire [15:0] receive_data_o,
  input wire receive_data_oe_o,
  input wire low_byte_control_flag_o,
  input wire low_byte_control_flag_oe_o,
  input wire high_byte_control_flag_o,
  input wire high_byte_control_flag_oe_o,
  input wire recovered_word_clock_o,
  input wire serial_out_negative_o,
  input wire serial_out_negative_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  wire rd_taken = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
  wire [7:0] hb = receive_data_o[15:8];
  wire rx_off = !receive_data_oe_o && !high_byte_control_flag_oe_o;
  a_loss_all_ones: assert property (signal_loss_detect_i [*6] |->
    receive_data_o == 16'hFFFF && low_byte_control_flag_o && high_byte_control_flag_o)
    else $error("loss not shown as all ones");
  a_high_code_valid: assert property (high_byte_control_flag_o &&
    high_byte_control_flag_oe_o |-> hb[4:0] == 5'h1C || hb == 8'hF7 || hb == 8'hFB ||
    hb == 8'hFD || hb == 8'hFE || hb == 8'h00 || hb == 8'hFF)
    else $error("upper control code outside valid set");
  a_por_quiet: assert property ($fell(reset_i) |->
    (rx_off && !low_byte_control_flag_oe_o && !recovered_word_clock_o) [*8])
    else $error("outputs driven during power-on reset");
  a_word_clock_held: assert property (rx_off |-> !recovered_word_clock_o)
    else $error("word clock high while receive side is held");
  a_rx_low_pair: assert property (receive_data_oe_o == low_byte_control_flag_oe_o)
    else $error("bus and low flag enables differ");
  a_high_oe_stays: assert property (receive_data_oe_o |-> high_byte_control_flag_oe_o)
    else $error("high flag floats while bus driven");
  a_word_low_half: assert property ($fell(recovered_word_clock_o) |->
    !recovered_word_clock_o [*8])
    else $error("word clock low half too short");
  a_read_data_hold: assert property (!rd_taken |=> $stable(hrdata_o))
    else $error("read data changed without a read");
  a_tx_complement: assert property (serial_out_negative_oe_o |->
    serial_out_negative_o == !$past(loopback_serial_i))
    else $error("serial output not the complement of the transmit bit");
  c_loss: cover property (signal_loss_detect_i [*6]);
  c_read: cover property (rd_taken);
  c_word: cover property ($rose(recovered_word_clock_o));
endmodule

bind serdes_receive_align_decode serdes_rx_sva #(
  .LOCK_WINDOW_CYCLES(LOCK_WINDOW_CYCLES),
  .POR_CYCLES(POR_CYCLES)
) u_serdes_rx_sva (.*);

// ==== tb/serial_link_model.sv ====
// remote transmitter: comma word with a chosen upper symbol, or the 2^7-1 pattern
// assumes data changes half a bit before each bit clock toggle
`timescale 1ns/1ps
module serial_link_model (
  input wire [9:0] upper_sym_i,
  input wire prbs_i,
  input wire [7:0] bit_ns_i,
  output reg line_p_o,
  output reg line_n_o,
  output reg bit_clk_o
);
  reg [9:0] sym_q;
  reg [6:0] lfsr_q;
  reg rd_neg_q;
  integer i;
  initial
  begin
    line_p_o = 1'b0;
    line_n_o = 1'b1;
    bit_clk_o = 1'b0;
    lfsr_q = 7'h7F;
    rd_neg_q = 1'b1;
    forever
    begin
      // comma character only in the lower lane, form chosen by running disparity
      sym_q = rd_neg_q ? 10'h17C : 10'h283;
      rd_neg_q = ~rd_neg_q;
      for (i = 0; i < 20; i = i + 1)
      begin
        if (i == 10)
          sym_q = upper_sym_i;
        lfsr_q = {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
        line_p_o = prbs_i ? lfsr_q[0] : sym_q[i % 10];
        line_n_o = ~line_p_o;
        #(bit_ns_i / 2);
        bit_clk_o = ~bit_clk_o;
        #(bit_ns_i / 2);
      end
    end
  end
endmodule

// ==== tb/test_serdes_receive_align_decode.sv ====
// bench for the receive block with a transmitter model on the serial pins
// assumes 40 MHz clock, short lock window and power-on count
`timescale 1ns/1ps
module test_serdes_receive_align_decode;
  reg clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg hsel_i = 1'b0;
  reg hwrite_i = 1'b0;
  reg [31:0] haddr_i = 32'h0;
  reg [31:0] hwdata_i = 32'h0;
  reg [1:0] htrans_i = 2'h0;
  reg [2:0] hsize_i = 3'h2;
  reg signal_loss_detect_i = 1'b0;
  reg loopback_serial_i = 1'b0;
  reg prbs = 1'b0;
  reg [9:0] upper_sym = 10'h155;
  reg [7:0] bit_ns = 8'h64;
  reg [31:0] rd;
  reg [27:0] rows [0:3];
  integer errors, samples_checked, k;
  wire hreadyout_o, hresp_o, serial_in_positive_i, serial_in_negative_i, serial_bit_clock_i;
  wire receive_data_oe_o, low_byte_control_flag_o, low_byte_control_flag_oe_o;
  wire high_byte_control_flag_o, high_byte_control_flag_oe_o, recovered_word_clock_o;
  wire serial_out_negative_o, serial_out_negative_oe_o;
  wire [31:0] hrdata_o;
  wire [15:0] receive_data_o;
  wire hready_i = hreadyout_o;
  wire [31:0] lanes = {14'h0, high_byte_control_flag_o, low_byte_control_flag_o, receive_data_o};

  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i)
    loopback_serial_i <= serial_in_positive_i;

  serdes_receive_align_decode #(
    .LOCK_WINDOW_CYCLES(400),
    .POR_CYCLES(20)
  ) u_serdes_receive_align_decode (.*);

  serial_link_model u_serial_link_model (
    .upper_sym_i(upper_sym),
    .prbs_i(prbs),
    .bit_ns_i(bit_ns),
    .line_p_o(serial_in_positive_i),
    .line_n_o(serial_in_negative_i),
    .bit_clk_o(serial_bit_clock_i)
  );

  task check(input [31:0] seen, input [31:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask

  task bus(input wr, input [31:0] addr, input [31:0] wdata, output [31:0] rdata);
  begin
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= addr;
    hwrite_i <= wr;
    @(posedge clk_i);
    while (hready_i !== 1'b1)
      @(posedge clk_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wdata;
    @(posedge clk_i);
    while (hready_i !== 1'b1)
      @(posedge clk_i);
    rdata = hrdata_o;
    check({31'h0, hresp_o}, 32'h0);
  end
  endtask

  // one word is twenty bits of four clocks each
  task words(input integer n);
  begin
    repeat (n * 80) @(posedge clk_i);
    @(negedge clk_i);
  end
  endtask

  task por_check;
  begin
    @(negedge clk_i);
    check({28'h0, receive_data_oe_o, low_byte_control_flag_oe_o, high_byte_control_flag_oe_o,
      recovered_word_clock_o}, 32'h0);
    bus(1'b0, 32'h4, 32'h0, rd);
    check(rd & 32'h10, 32'h10);
    bus(1'b0, 32'h0, 32'h0, rd);
    check(rd, 32'h1);
  end
  endtask

  task final_report;
  begin
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask

  initial
  begin
    #1000000;
    errors = errors + 1;
    $display("ERROR %0t: timeout", $time);
    final_report;
  end

  initial
  begin
    errors = 0;
    samples_checked = 0;
    rows[0] = {10'h155, 18'h1B5BC};
    rows[1] = {10'h343, 18'h31CBC};
    rows[2] = {10'h3A8, 18'h3F7BC};
    rows[3] = {10'h000, 18'h300BC};
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    por_check;
    k = 0;
    rd = 32'h0;
    while (rd[0] !== 1'b1 && k < 40)
    begin
      words(1);
      bus(1'b0, 32'h4, 32'h0, rd);
      k = k + 1;
    end
    // alignment is dropped while unlocked and returns at the next positive comma
    words(2);
    bus(1'b0, 32'h4, 32'h0, rd);
    check(rd & 32'hD, 32'hD);
    for (k = 0; k < 4; k = k + 1)
    begin
      upper_sym <= rows[k][27:18];
      words(4);
      check(lanes, {14'h0, rows[k][17:0]});
    end
    upper_sym <= 10'h155;
    words(4);
    bus(1'b0, 32'h8, 32'h0, rd);
    check(rd, 32'h1B5BC);
    bus(1'b0, 32'h10, 32'h0, rd);
    check({31'h0, rd != 32'h0}, 32'h1);
    bus(1'b1, 32'h10, 32'h0, rd);
    bus(1'b0, 32'h10, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b0, 32'h40, 32'h0, rd);
    check(rd, 32'h0);
    @(posedge clk_i);
    signal_loss_detect_i <= 1'b1;
    words(1);
    check(lanes, 32'h3FFFF);
    bus(1'b0, 32'h4, 32'h0, rd);
    check(rd & 32'h2, 32'h2);
    signal_loss_detect_i <= 1'b0;
    bus(1'b1, 32'h0, 32'h3, rd);
    words(2);
    check({30'h0, serial_out_negative_oe_o, low_byte_control_flag_o}, 32'h2);
    prbs <= 1'b1;
    words(3);
    check({31'h0, low_byte_control_flag_o}, 32'h1);
    bus(1'b0, 32'hC, 32'h0, rd);
    check({31'h0, rd != 32'h0}, 32'h1);
    bus(1'b1, 32'hC, 32'h0, rd);
    bus(1'b0, 32'hC, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b1, 32'h0, 32'h7, rd);
    words(3);
    check({30'h0, serial_out_negative_oe_o, low_byte_control_flag_o}, 32'h1);
    bit_ns <= 8'h6E;
    words(15);
    bus(1'b0, 32'h4, 32'h0, rd);
    check(rd & 32'h1, 32'h0);
    bus(1'b1, 32'h0, 32'h0, rd);
    words(1);
    check({28'h0, receive_data_oe_o, low_byte_control_flag_oe_o, serial_out_negative_oe_o,
      high_byte_control_flag_oe_o}, 32'h1);
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    por_check;
    final_report;
  end
endmodule
